// ---- verilog/pv_alarm.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pv_alarm_regs.svh"
module pv_alarm #(
  parameter bit CLAMP_EN = 1'b0,
  parameter logic [15:0] RAW_FULL = `PV_RAW_FULL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic conv_i,
  input wire logic [15:0] raw_i,
  input wire pv_alarm_pkg::pv_t scale_min_i,
  input wire pv_alarm_pkg::pv_t scale_max_i,
  input wire pv_alarm_pkg::pv_t set_value_i [4],
  input wire pv_alarm_pkg::pv_t hysteresis_i [4],
  input wire logic [15:0] on_delay_i [4],
  input wire logic [15:0] off_delay_i [4],
  output logic [15:0] pv_o,
  output logic pv_valid_o,
  output logic upper_critical_trip_o,
  output logic upper_warning_trip_o,
  output logic bottom_warning_trip_o,
  output logic lower_critical_trip_o
);
  // index: 0 upper critical, 1 upper warning, 2 bottom warn, 3 lower crit
  pv_alarm_pkg::pv_t pv_q, pv_d;
  logic valid_q, valid_d;
  logic [3:0] alarm_q, alarm_d;
  logic [3:0] alarm_w;
  logic signed [17:0] span;
  logic signed [34:0] prod;
  logic signed [34:0] quot;
  logic signed [35:0] sum;

  // ==========================================================
  // scaling
  // span is signed, so max below min gives a falling line
  always_comb begin
    span = {{2{scale_max_i[15]}}, scale_max_i}
         - {{2{scale_min_i[15]}}, scale_min_i};
    // both factors widened first so no tool keeps the product at 18 bits
    prod = 35'(span) * 35'($signed({1'b0, raw_i}));
    quot = prod / $signed({19'h0_0000, RAW_FULL});
    sum = {quot[34], quot} + 36'({{20{scale_min_i[15]}}, scale_min_i});
    pv_d = pv_q;
    valid_d = 1'b0;
    if (conv_i) begin
      valid_d = 1'b1;
      if (sum > 36'sh7fff) pv_d = 16'sh7fff;
      else if (sum < -36'sh8000) pv_d = -16'sh8000;
      else pv_d = sum[15:0];
      if (CLAMP_EN) begin
        if ($signed(pv_d) > `PV_CLAMP_HI) pv_d = `PV_CLAMP_HI;
        if ($signed(pv_d) < `PV_CLAMP_LO) pv_d = `PV_CLAMP_LO;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pv_q <= 16'sh0000;
      valid_q <= 1'b0;
    end else begin
      pv_q <= pv_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================
  // alarm channels, one per set value
  // channels run on the newly registered scaled value, one clock after the conversion strobe
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_alarm
      pv_alarm_if cfg_if ();
      assign cfg_if.set_value = set_value_i[g];
      assign cfg_if.hysteresis = hysteresis_i[g];
      assign cfg_if.on_delay = on_delay_i[g];
      assign cfg_if.off_delay = off_delay_i[g];
      assign cfg_if.upper = (g < 2);
      assign alarm_w[g] = cfg_if.alarm;
      pv_alarm_chan u_chan (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .conv_i(valid_q),
        .pv_i(pv_q),
        .cfg(cfg_if)
      );
    end
  endgenerate

  // ==========================================================
  // output registers
  always_comb begin
    alarm_d = alarm_w;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) alarm_q <= 4'h0;
    else alarm_q <= alarm_d;
  end

  assign pv_o = pv_q;
  assign pv_valid_o = valid_q;
  assign upper_critical_trip_o = alarm_q[0];
  assign upper_warning_trip_o = alarm_q[1];
  assign bottom_warning_trip_o = alarm_q[2];
  assign lower_critical_trip_o = alarm_q[3];
endmodule
`default_nettype wire

// ---- verilog/pv_alarm_regs.svh ----
// Contract
// - upper alarm held until input below new set value minus hysteresis
// - lower alarm held until input above new set value plus hysteresis
// - set values in any order; each alarm compares only its own set value
// - upper alarms trip when scaled value exceeds their set value
// - lower alarms trip when scaled value is below their set value
// - alarm stays off if condition drops out before on-delay elapses
// - alarm stays on if off condition drops out before off-delay elapses
// - negative bias: max below min gives inverted slope scaling
// - alarms compare the scaled process value, never the raw input
// - clamp variant limits scaled value to 4200 and -200
`ifndef PV_ALARM_REGS_SVH
`define PV_ALARM_REGS_SVH
`define PV_CLAMP_HI 16'sh1068
`define PV_CLAMP_LO (-16'sh00c8)
`define PV_RAW_FULL 16'h0fa0
`define PV_DELAY_RST 16'h0000
`endif

// ---- verilog/pv_alarm_pkg.sv ----
`default_nettype none
package pv_alarm_pkg;
  typedef logic signed [15:0] pv_t;
  // state of one delayed alarm; gray codes along off->pend_on->on->pend_off
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_PEND_ON = 2'b01,
    ST_ON = 2'b11,
    ST_PEND_OFF = 2'b10
  } alarm_state_t;
endpackage
`default_nettype wire

// ---- verilog/pv_alarm_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// per-alarm settings and result passed to a channel
interface pv_alarm_if;
  pv_alarm_pkg::pv_t set_value;
  pv_alarm_pkg::pv_t hysteresis;
  logic [15:0] on_delay;
  logic [15:0] off_delay;
  logic upper;
  logic alarm;
  modport ctrl (output set_value, output hysteresis, output on_delay,
    output off_delay, output upper, input alarm);
  modport chan (input set_value, input hysteresis, input on_delay,
    input off_delay, input upper, output alarm);
endinterface
`default_nettype wire

// ---- verilog/pv_alarm_chan.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pv_alarm_regs.svh"
module pv_alarm_chan (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic conv_i,
  input wire pv_alarm_pkg::pv_t pv_i,
  pv_alarm_if.chan cfg
);
  pv_alarm_pkg::alarm_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic on_cond, off_cond;
  logic signed [16:0] pv_x, sv_x, hy_x;

  // ==========================================================
  // condition evaluation
  // each alarm looks only at its own set value
  always_comb begin
    pv_x = {pv_i[15], pv_i};
    sv_x = {cfg.set_value[15], cfg.set_value};
    hy_x = {cfg.hysteresis[15], cfg.hysteresis};
    if (cfg.upper) begin
      on_cond = pv_x > sv_x;
      // set value read live, so a raised value moves the release point
      off_cond = pv_x < (sv_x - hy_x);
    end else begin
      on_cond = pv_x < sv_x;
      off_cond = pv_x > (sv_x + hy_x);
    end
  end

  // ==========================================================
  // delay state machine, stepping once per conversion
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (conv_i) begin
      unique case (st_q)
        pv_alarm_pkg::ST_OFF: begin
          cnt_d = `PV_DELAY_RST;
          if (on_cond) begin
            if (cfg.on_delay == 16'h0000) st_d = pv_alarm_pkg::ST_ON;
            else st_d = pv_alarm_pkg::ST_PEND_ON;
          end
        end
        pv_alarm_pkg::ST_PEND_ON: begin
          if (!on_cond) begin
            st_d = pv_alarm_pkg::ST_OFF;
            cnt_d = `PV_DELAY_RST;
          end else if (cnt_q + 16'h0001 >= cfg.on_delay) begin
            st_d = pv_alarm_pkg::ST_ON;
            cnt_d = `PV_DELAY_RST;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        pv_alarm_pkg::ST_ON: begin
          cnt_d = `PV_DELAY_RST;
          if (off_cond) begin
            if (cfg.off_delay == 16'h0000) st_d = pv_alarm_pkg::ST_OFF;
            else st_d = pv_alarm_pkg::ST_PEND_OFF;
          end
        end
        pv_alarm_pkg::ST_PEND_OFF: begin
          if (!off_cond) begin
            st_d = pv_alarm_pkg::ST_ON;
            cnt_d = `PV_DELAY_RST;
          end else if (cnt_q + 16'h0001 >= cfg.off_delay) begin
            st_d = pv_alarm_pkg::ST_OFF;
            cnt_d = `PV_DELAY_RST;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= pv_alarm_pkg::ST_OFF;
      cnt_q <= `PV_DELAY_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // pending-off still reports the alarm as active
  assign cfg.alarm = (st_q == pv_alarm_pkg::ST_ON) ||
                     (st_q == pv_alarm_pkg::ST_PEND_OFF);
endmodule
`default_nettype wire

// ---- dv/pv_alarm_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pv_alarm_regs.svh"
module pv_alarm_properties #(parameter bit CLAMP_EN = 1'b0) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic conv_i,
  input wire pv_alarm_pkg::pv_t set_value_i [4],
  input wire logic [15:0] on_delay_i [4],
  input wire logic [15:0] pv_o,
  input wire logic pv_valid_o,
  input wire logic upper_critical_trip_o,
  input wire logic upper_warning_trip_o,
  input wire logic bottom_warning_trip_o,
  input wire logic lower_critical_trip_o
);
  // ====
  // latency and alarm cause
  // reset seen one edge late, so $past one cycle back never reaches pre-reset values
  logic rst_seen_q;
  always @(posedge clk_i) rst_seen_q <= rst_n_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !rst_seen_q);
  logic [3:0] trips;
  assign trips = {upper_critical_trip_o, upper_warning_trip_o,
    bottom_warning_trip_o, lower_critical_trip_o};
  a_valid_after_conv: assert property
    (conv_i |=> pv_valid_o) else $error("no valid after strobe");
  a_pv_holds: assert property
    (!pv_valid_o |-> $stable(pv_o)) else $error("pv moved without valid");
  a_trip_on_conv: assert property
    ($changed(trips) |-> $past(conv_i, 3)) else $error("alarm moved late");
  a_clamp_range: assert property
    (pv_valid_o && CLAMP_EN |-> $signed(pv_o) <= `PV_CLAMP_HI &&
    $signed(pv_o) >= `PV_CLAMP_LO) else $error("pv out of clamp");
  a_warn_on: assert property
    (pv_valid_o && $signed(pv_o) > set_value_i[1] && on_delay_i[1] == 0
    |-> ##2 upper_warning_trip_o) else $error("warning not raised");
  a_low_on: assert property
    (pv_valid_o && $signed(pv_o) < set_value_i[3] && on_delay_i[3] == 0
    |-> ##2 lower_critical_trip_o) else $error("low alarm not raised");
  a_crit_rise_cause: assert property
    ($rose(upper_critical_trip_o) |-> $past(pv_valid_o, 2) &&
    $signed($past(pv_o, 2)) > $past(set_value_i[0], 2))
    else $error("critical rose without cause");
  a_bot_rise_cause: assert property
    ($rose(bottom_warning_trip_o) |-> $past(pv_valid_o, 2) &&
    $signed($past(pv_o, 2)) < $past(set_value_i[2], 2))
    else $error("bottom rose without cause");
  c_crit_on: cover property ($rose(upper_critical_trip_o));
  c_low_off: cover property ($fell(lower_critical_trip_o));
  c_clamp: cover property (pv_valid_o && pv_o == `PV_CLAMP_HI);
endmodule
bind pv_alarm pv_alarm_properties #(.CLAMP_EN(CLAMP_EN)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_i(conv_i), .pv_o(pv_o),
  .set_value_i(set_value_i), .on_delay_i(on_delay_i),
  .pv_valid_o(pv_valid_o), .upper_critical_trip_o(upper_critical_trip_o),
  .upper_warning_trip_o(upper_warning_trip_o),
  .bottom_warning_trip_o(bottom_warning_trip_o),
  .lower_critical_trip_o(lower_critical_trip_o));
`default_nettype wire

// ---- dv/pv_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module pv_host (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [15:0] code_i,
  input wire logic pv_valid_i,
  input wire logic [15:0] pv_i,
  output logic conv_o,
  output logic [15:0] raw_o,
  output logic [15:0] pv_seen_o
);
  // raw code shows its inverse between strobes so a late sample shows up
  always @(posedge clk_i) begin
    conv_o <= req_i;
    raw_o <= req_i ? code_i : ~code_i;
    if (pv_valid_i)
      pv_seen_o <= pv_i;
  end
endmodule
`default_nettype wire

// ---- dv/pv_alarm_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module pv_alarm_tb;
  logic clk_i, rst_n_i, req, conv_i, pv_valid_o;
  logic [15:0] raw_i, code, pv_o, pv_seen, x, lfsr = 16'h0061;
  pv_alarm_pkg::pv_t smin, smax, sv [4], hy [4];
  logic [15:0] ond [4] = '{16'h0002, 16'h0000, 16'h0001, 16'h0000};
  logic [15:0] offd [4] = '{16'h0001, 16'h0000, 16'h0002, 16'h0003};
  logic [3:0] exp_on = 4'h0;
  wire [3:0] trip;
  int n_fail = 0, check_count = 0, cyc = 0, cnt [4] = '{default: 0};
  int cor [14][3] = '{'{1, 100, 2000}, '{1, 3000, 2960}, '{1, -1, 2900},
    '{3, 3000, 100}, '{3, 50, 80}, '{3, -1, 120}, '{0, 1000, 1500},
    '{0, -1, 1500}, '{0, -1, 500}, '{0, -1, 1500}, '{0, -1, 1500},
    '{0, -1, 1500}, '{0, -1, 500}, '{0, -1, 1500}};
  pv_alarm #(.CLAMP_EN(1'b1)) u_pv_alarm (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .conv_i(conv_i), .raw_i(raw_i), .scale_min_i(smin), .scale_max_i(smax),
    .set_value_i(sv), .hysteresis_i(hy), .on_delay_i(ond),
    .off_delay_i(offd), .pv_o(pv_o), .pv_valid_o(pv_valid_o),
    .upper_critical_trip_o(trip[0]), .upper_warning_trip_o(trip[1]),
    .bottom_warning_trip_o(trip[2]), .lower_critical_trip_o(trip[3]));
  pv_host u_pv_host (.clk_i(clk_i), .req_i(req), .code_i(code),
    .pv_valid_i(pv_valid_o), .pv_i(pv_o), .conv_o(conv_i), .raw_o(raw_i),
    .pv_seen_o(pv_seen));
  // ====
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end
  // ====
  // helpers; the model reads settings live as the block does
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [15:0] exp_pv(logic [15:0] r);
    int v;
    v = smin + (smax - smin) * int'(r) / 4000;
    v = v > 4200 ? 4200 : v < -200 ? -200 : v;
    return v[15:0];
  endfunction
  task automatic model(int p);
    for (int i = 0; i < 4; i++) begin
      bit c;
      c = exp_on[i] ? (i < 2 ? p < sv[i] - hy[i] : p > sv[i] + hy[i])
        : (i < 2 ? p > sv[i] : p < sv[i]);
      if (!c)
        cnt[i] = 0;
      else if (cnt[i] == (exp_on[i] ? offd[i] : ond[i])) begin
        exp_on[i] = ~exp_on[i];
        cnt[i] = 0;
      end else
        cnt[i]++;
    end
  endtask
  task automatic check(string what, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic step(logic [15:0] r);
    @(posedge clk_i);
    code <= r;
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    model(int'($signed(exp_pv(r))));
    check("pv", exp_pv(r), pv_seen);
    check("trips", {12'h000, exp_on}, {12'h000, trip});
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ====
  // plain, inverted and clamped scaling, then hand-made cases
  initial begin
    rst_n_i = 1'b0;
    req = 1'b0;
    code = 16'h0000;
    sv = '{default: 16'sh0000};
    hy = '{default: 16'sh0000};
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int ph = 0; ph < 3; ph++) begin
      @(posedge clk_i);
      smin <= ph == 1 ? 16'sh0fa0 : ph == 2 ? -16'sh03e8 : 16'sh0000;
      smax <= ph == 1 ? 16'sh0000 : ph == 2 ? 16'sh1388 : 16'sh0fa0;
      step(16'h0000);
      step(16'h0fa0);
      repeat (40) begin
        @(posedge clk_i);
        for (int a = 0; a < 4; a++) begin
          x = rnd();
          sv[a] <= {4'h0, x[11:0]};
          hy[a] <= {12'h000, x[15:12]};
        end
        x = rnd();
        step(x % 16'h0fa1);
      end
      $display("scaling phase %0d done", ph);
    end
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    smin <= 16'sh0000;
    smax <= 16'sh0fa0;
    sv <= '{16'sh0fa0, 16'sh0fa0, 16'sh0000, 16'sh0000};
    hy <= '{default: 16'sh0032};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    exp_on = 4'h0;
    cnt = '{default: 0};
    foreach (cor[k]) begin
      @(posedge clk_i);
      if (cor[k][1] >= 0)
        sv[cor[k][0]] <= cor[k][1][15:0];
      step(cor[k][2][15:0]);
    end
    $display("corner cases done");
    test_done();
  end
endmodule
`default_nettype wire
